// ===== hdl/tmrz_timer.sv
// Eight/sixteen bit timer with prescaler, postscaler and AXI4-Lite registers
// Behaviour
// - Async mode counts every source or prescaler edge
// - Sync mode counts at most instruction clock rate
// - Three-bit field picks the count source
// - Internal source makes a prescaled timer
// - External source counts prescaled rising edges
// - Prescaler divides by two to the n
// - Prescaler hidden; cleared by low/control-b writes
// - Postscaler divides events by n plus one
// - Postscaler hidden; cleared by low/control-a writes
// - Sleep stops sync counter, async keeps counting
// - Event on period match or 16-bit rollover
// - Flag set every postscale-plus-one events
// - Enabled flag interrupts and wakes the CPU
// - Output pulses per postscaled event, derived toggles
// - Output to peripherals and status bit five
// - Enable bit seven runs or idles module
// - Bit four selects width, bit six zero
// - Low read latches true high byte
// - Low write loads high from buffer
// - Match clears low, reloads period buffer
// - Reset clears low, high becomes FFh
module tmrz_timer
  import tmrz_pkg::*;
#(
  parameter int PRESCALE_W = 15
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire tmrz_pkg::tmrz_axi_req_t axi_req,
  output tmrz_pkg::tmrz_axi_rsp_t axi_rsp,
  input wire tmrz_pkg::tmrz_src_in_t src_in,
  input wire logic sleep_active,
  output logic event_pulse,
  output logic event_toggle,
  output logic event_irq,
  output logic wake_req
);
  import tmrz_pkg::*;

  // Elaboration check: the prescaler counter is fixed at fifteen bits, its four-bit field picks one of sixteen ratios
  if (PRESCALE_W != 15) begin : g_bad_prescale
    $error("prescaler must be 15 bits for sixteen ratios");
  end

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] hi_buf;
    logic [7:0] period;
    logic flag;
    logic irq_en;
    logic [14:0] pre;
    logic [3:0] post;
    logic [1:0] sync;
    logic sync_prev;
    logic raw_prev;
    logic [1:0] idiv;
    logic pulse;
    logic toggle;
    logic aw_got;
    logic [4:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tmrz_state_t;

  tmrz_state_t s_q;
  tmrz_state_t s_d;

  // ==========================================================
  // Register selects
  localparam logic [2:0] SEL_CTRL_A = 3'h0;
  localparam logic [2:0] SEL_CTRL_B = 3'h1;
  localparam logic [2:0] SEL_CNT_LO = 3'h2;
  localparam logic [2:0] SEL_CNT_HI = 3'h3;
  localparam logic [2:0] SEL_IRQ = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // Register index decode, used by read and write sides
  // Misaligned and unmapped addresses fall to the error select
  function automatic logic [2:0] tmrz_decode(input logic [4:0] a);
    unique case (a)
      {1'b0, TMRZ_OFS_CTRL_A}: tmrz_decode = SEL_CTRL_A;
      {1'b0, TMRZ_OFS_CTRL_B}: tmrz_decode = SEL_CTRL_B;
      {1'b0, TMRZ_OFS_CNT_LO}: tmrz_decode = SEL_CNT_LO;
      {1'b0, TMRZ_OFS_CNT_HI}: tmrz_decode = SEL_CNT_HI;
      TMRZ_OFS_IRQ_REG: tmrz_decode = SEL_IRQ;
      default: tmrz_decode = SEL_NONE;
    endcase
  endfunction

  logic raw_src;
  logic src_valid;
  logic sync_mode;
  logic edge_in;
  logic pre_tick;
  logic inc;
  logic match8;
  logic roll16;
  logic cnt_event;
  logic post_done;
  logic [14:0] pre_mask;
  logic [15:0] cnt_next;
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic do_write;
  logic do_read;
  logic wr_lo;
  logic [7:0] wbyte;

  always_comb begin
    s_d = s_q;

    // ========================================================
    // Source selection
    // source select decode
    src_valid = 1'b1;
    unique case (tmrz_src_t'(s_q.ctrl_b[7:5]))
      TMRZ_SRC_PIN_TRUE: raw_src = src_in.pin;
      TMRZ_SRC_PIN_INV: raw_src = ~src_in.pin;
      TMRZ_SRC_INSTR: raw_src = s_q.idiv[1];
      TMRZ_SRC_HFOSC: raw_src = src_in.hfosc;
      TMRZ_SRC_LFOSC: raw_src = src_in.lfosc;
      TMRZ_SRC_SECONDARY_OSC: raw_src = src_in.secondary_osc;
      TMRZ_SRC_LC1: raw_src = src_in.lc1;
      default: begin
        raw_src = 1'b0;
        src_valid = 1'b0;
      end
    endcase

    sync_mode = ~s_q.ctrl_b[TMRZ_B_ASYNC];
    s_d.idiv = s_q.idiv + 2'h1;
    s_d.sync = {s_q.sync[0], raw_src};
    s_d.raw_prev = raw_src;
    if (s_q.idiv == 2'h3) begin
      s_d.sync_prev = s_q.sync[1];
    end
    // async uses raw edges, sync one per instruction cycle
    if (sync_mode) begin
      edge_in = (s_q.idiv == 2'h3) && s_q.sync[1] && !s_q.sync_prev;
      // Instruction clock sits on the tick grid; sampling it there would alias to a level
      if (tmrz_src_t'(s_q.ctrl_b[7:5]) == TMRZ_SRC_INSTR) begin
        edge_in = (s_q.idiv == 2'h3);
      end
    end else begin
      edge_in = raw_src && !s_q.raw_prev;
    end
    // disabled or sleeping sync counter halts
    edge_in = edge_in && src_valid && s_q.ctrl_a[TMRZ_A_EN]
      && !(sleep_active && sync_mode);

    // ========================================================
    // Prescaler
    // divide by two to the n
    pre_mask = 15'((16'h1 << s_q.ctrl_b[3:0]) - 16'h1);
    pre_tick = 1'b0;
    if (edge_in) begin
      if ((s_q.pre & pre_mask) == pre_mask) begin
        pre_tick = 1'b1;
        s_d.pre = 15'h0;
      end else begin
        s_d.pre = s_q.pre + 15'h1;
      end
    end
    inc = pre_tick;

    // ========================================================
    // Counter and events
    cnt_next = {s_q.cnt_hi, s_q.cnt_lo} + 16'h1;
    match8 = !s_q.ctrl_a[TMRZ_A_WIDE] && (s_q.cnt_lo == s_q.period);
    roll16 = s_q.ctrl_a[TMRZ_A_WIDE] && ({s_q.cnt_hi, s_q.cnt_lo} == 16'hffff);
    cnt_event = inc && (match8 || roll16);
    if (inc) begin
      if (s_q.ctrl_a[TMRZ_A_WIDE]) begin
        s_d.cnt_lo = cnt_next[7:0];
        s_d.cnt_hi = cnt_next[15:8];
      end else if (match8) begin
        s_d.cnt_lo = 8'h00;
        s_d.period = s_q.hi_buf;
      end else begin
        s_d.cnt_lo = s_q.cnt_lo + 8'h01;
      end
    end
    post_done = 1'b0;
    if (cnt_event) begin
      if (s_q.post == s_q.ctrl_a[3:0]) begin
        post_done = 1'b1;
        s_d.post = 4'h0;
      end else begin
        s_d.post = s_q.post + 4'h1;
      end
    end
    // pulse held until the next counter increment, toggle on its rise
    if (post_done) begin
      s_d.pulse = 1'b1;
      if (!s_q.pulse) begin
        s_d.toggle = ~s_q.toggle;
      end
    end else if (inc) begin
      s_d.pulse = 1'b0;
    end

    // ========================================================
    // AXI4-Lite slave
    if (axi_req.awvalid && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    wsel = tmrz_decode(s_q.awaddr);
    wbyte = s_q.wdata[7:0];
    wr_lo = 1'b0;
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wsel == SEL_NONE) ? TMRZ_RESP_SLVERR : TMRZ_RESP_OKAY;
      if (s_q.wstrb[0]) begin
        unique case (wsel)
          SEL_CTRL_A: begin
            s_d.ctrl_a = {wbyte[7], 1'b0, 1'b0, wbyte[4:0]};
            s_d.post = 4'h0;
          end
          SEL_CTRL_B: begin
            s_d.ctrl_b = wbyte;
            s_d.pre = 15'h0;
          end
          SEL_CNT_LO: begin
            // low write clears scalers, loads high
            wr_lo = 1'b1;
            s_d.cnt_lo = wbyte;
            s_d.pre = 15'h0;
            s_d.post = 4'h0;
            if (s_q.ctrl_a[TMRZ_A_WIDE]) begin
              s_d.cnt_hi = s_q.hi_buf;
            end
          end
          SEL_CNT_HI: begin
            s_d.hi_buf = wbyte;
          end
          SEL_IRQ: begin
            s_d.irq_en = wbyte[TMRZ_IRQ_EN];
            if (wbyte[TMRZ_IRQ_FLAG] == 1'b0) begin
              s_d.flag = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end

    // flag set wins over software clear
    if (post_done) begin
      s_d.flag = 1'b1;
    end

    do_read = axi_req.arvalid && !s_q.rvalid;
    rsel = tmrz_decode(axi_req.araddr);
    if (do_read) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = (rsel == SEL_NONE) ? TMRZ_RESP_SLVERR : TMRZ_RESP_OKAY;
      s_d.rdata = 32'h0;
      unique case (rsel)
        SEL_CTRL_A: s_d.rdata[7:0] = {s_q.ctrl_a[7], 1'b0, s_q.pulse, s_q.ctrl_a[4:0]};
        SEL_CTRL_B: s_d.rdata[7:0] = s_q.ctrl_b;
        SEL_CNT_LO: begin
          s_d.rdata[7:0] = s_q.cnt_lo;
          if (s_q.ctrl_a[TMRZ_A_WIDE] && !wr_lo) begin
            s_d.hi_buf = s_q.cnt_hi;
          end
        end
        SEL_CNT_HI: s_d.rdata[7:0] = s_q.hi_buf;
        SEL_IRQ: s_d.rdata[1:0] = {s_q.irq_en, s_q.flag};
        default: s_d.rdata = 32'h0;
      endcase
    end
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ctrl_a <= TMRZ_RST_CTRL_A;
      s_q.ctrl_b <= TMRZ_RST_CTRL_B;
      s_q.cnt_lo <= TMRZ_RST_CNT_LO;
      s_q.cnt_hi <= TMRZ_RST_CNT_HI;
      s_q.hi_buf <= TMRZ_RST_CNT_HI;
      s_q.period <= TMRZ_RST_CNT_HI;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign axi_rsp.awready = !s_q.aw_got;
  assign axi_rsp.wready = !s_q.w_got;
  assign axi_rsp.bvalid = s_q.bvalid;
  assign axi_rsp.bresp = s_q.bresp;
  assign axi_rsp.arready = !s_q.rvalid;
  assign axi_rsp.rvalid = s_q.rvalid;
  assign axi_rsp.rdata = s_q.rdata;
  assign axi_rsp.rresp = s_q.rresp;
  assign event_pulse = s_q.pulse;
  assign event_toggle = s_q.toggle;
  assign event_irq = s_q.flag && s_q.irq_en;
  assign wake_req = s_q.flag && s_q.irq_en && sleep_active;

endmodule

// ===== hdl/tmrz_pkg.sv
// Package for the eight/sixteen bit timer with prescaler and postscaler
package tmrz_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [3:0] TMRZ_OFS_CTRL_A = 4'h0;
  localparam logic [3:0] TMRZ_OFS_CTRL_B = 4'h4;
  localparam logic [3:0] TMRZ_OFS_CNT_LO = 4'h8;
  localparam logic [3:0] TMRZ_OFS_CNT_HI = 4'hc;
  localparam logic [3:0] TMRZ_OFS_IRQ = 4'h0;
  localparam int TMRZ_ADDR_W = 5;
  localparam logic [4:0] TMRZ_OFS_IRQ_REG = 5'h10;

  // ==========================================================
  // Field positions
  localparam int TMRZ_A_EN = 7;
  localparam int TMRZ_A_OUT = 5;
  localparam int TMRZ_A_WIDE = 4;
  localparam int TMRZ_B_ASYNC = 4;
  localparam int TMRZ_IRQ_FLAG = 0;
  localparam int TMRZ_IRQ_EN = 1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] TMRZ_RST_CTRL_A = 8'h00;
  localparam logic [7:0] TMRZ_RST_CTRL_B = 8'h00;
  localparam logic [7:0] TMRZ_RST_CNT_LO = 8'h00;
  localparam logic [7:0] TMRZ_RST_CNT_HI = 8'hff;

  // ==========================================================
  // Count source codes
  typedef enum logic [2:0] {
    TMRZ_SRC_PIN_TRUE = 3'h0,
    TMRZ_SRC_PIN_INV = 3'h1,
    TMRZ_SRC_INSTR = 3'h2,
    TMRZ_SRC_HFOSC = 3'h3,
    TMRZ_SRC_LFOSC = 3'h4,
    TMRZ_SRC_RSVD = 3'h5,
    TMRZ_SRC_SECONDARY_OSC = 3'h6,
    TMRZ_SRC_LC1 = 3'h7
  } tmrz_src_t;

  // Instruction clock is the system clock divided by four
  localparam int TMRZ_INSTR_DIV = 4;

  // ==========================================================
  // AXI4-Lite carriers
  localparam logic [1:0] TMRZ_RESP_OKAY = 2'h0;
  localparam logic [1:0] TMRZ_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [4:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [4:0] araddr;
    logic arvalid;
    logic rready;
  } tmrz_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } tmrz_axi_rsp_t;

  // Clock source inputs, all sampled as synchronous levels
  typedef struct packed {
    logic pin;
    logic hfosc;
    logic lfosc;
    logic secondary_osc;
    logic lc1;
  } tmrz_src_in_t;

endpackage

// ===== tb/tmrz_timer_properties.sv
// Checker for the timer register bus and event outputs
module tmrz_timer_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire tmrz_pkg::tmrz_axi_req_t axi_req,
  input wire tmrz_pkg::tmrz_axi_rsp_t axi_rsp,
  input wire tmrz_pkg::tmrz_src_in_t src_in,
  input wire logic sleep_active,
  input wire logic event_pulse,
  input wire logic event_toggle,
  input wire logic event_irq,
  input wire logic wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmrz_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // Assertions
  a_wake_from_irq: assert property (wake_req == (event_irq && sleep_active))
    else $error("wake request differs from enabled flag in sleep");
  a_toggle_on_rise: assert property ($rose(event_pulse) |-> ##[0:1] $changed(event_toggle))
    else $error("derived output missed a pulse");
  a_toggle_in_pulse: assert property ($changed(event_toggle) |-> event_pulse)
    else $error("derived output moved without a pulse");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid)
    else $error("write answer late");
  a_write_blocks: assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
    else $error("write slot accepted while busy");
  a_read_blocks: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read accepted while answer pending");
  a_upper_zero: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  c_pulse: cover property ($rose(event_pulse));
  c_wake: cover property (wake_req);
  c_slverr: cover property (axi_rsp.bvalid && axi_rsp.bresp == TMRZ_RESP_SLVERR);
endmodule

// ===== tb/tmrz_src_model.sv
// Model of the external count pin feeding the timer sources
module tmrz_src_model #(
  parameter int HALF = 8
) (
  input wire logic clk_sys,
  input wire logic run,
  output tmrz_pkg::tmrz_src_in_t src
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmrz_pkg::*;
  int cnt = 0;
  logic pin = 1'b0;
  // Pin stands low between bursts, other sources idle
  assign src = {pin, 4'h0};
  always @(posedge clk_sys) begin
    if (!run) begin
      cnt <= 0;
      pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= !pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ===== tb/tmrz_timer_tb.sv
// Self-checking bench for the timer
module tmrz_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tmrz_pkg::*;
  typedef struct {logic [4:0] a; logic [7:0] w; logic [7:0] e; logic [1:0] rs;} tmrz_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sleep_active = 1'b0;
  logic run = 1'b0;
  tmrz_axi_req_t req = '0;
  tmrz_axi_rsp_t rsp;
  tmrz_src_in_t src;
  logic event_pulse, event_toggle, event_irq, wake_req;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  logic [1:0] r;
  logic [7:0] d;
  logic t0;
  tmrz_row_t rows [7] = '{'{5'h00, 8'h5f, 8'h1f, 2'h0}, '{5'h04, 8'he7, 8'he7, 2'h0},
    '{5'h0c, 8'h3c, 8'h3c, 2'h0}, '{5'h08, 8'h12, 8'h12, 2'h0}, '{5'h10, 8'h02, 8'h02, 2'h0},
    '{5'h14, 8'h55, 8'h00, 2'h2}, '{5'h02, 8'h55, 8'h00, 2'h2}};
  logic [2:0] cs [4] = '{3'h0, 3'h1, 3'h0, 3'h5};
  logic asy [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic [7:0] ecnt [4] = '{8'h0a, 8'h0a, 8'h0a, 8'h00};

  tmrz_timer tmrz_timer_i (.clk_sys(clk_sys), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
    .src_in(src), .sleep_active(sleep_active), .event_pulse(event_pulse),
    .event_toggle(event_toggle), .event_irq(event_irq), .wake_req(wake_req));
  tmrz_src_model #(.HALF(8)) tmrz_src_model_i (.clk_sys(clk_sys), .run(run), .src(src));

  initial forever #12.5 clk_sys = ~clk_sys;

  // ==========
  // Tasks
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic stall(input string nm);
    $display("MISMATCH %s expected done seen timeout", nm);
    bad_count++;
    wrap_up();
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v, output logic [1:0] resp);
    logic ha, hw, hb;
    @(posedge clk_sys);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= {24'h0, v};
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    hb = 1'b0;
    for (int k = 0; k < 40 && !hb; k++) begin
      @(negedge clk_sys);
      ha = req.awvalid && rsp.awready;
      hw = req.wvalid && rsp.wready;
      hb = req.bready && rsp.bvalid;
      resp = rsp.bresp;
      @(posedge clk_sys);
      if (ha) req.awvalid <= 1'b0;
      if (hw) req.wvalid <= 1'b0;
      if (hb) req.bready <= 1'b0;
    end
    if (!hb) stall("write");
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] v, output logic [1:0] resp);
    logic ha, hr;
    @(posedge clk_sys);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    hr = 1'b0;
    for (int k = 0; k < 40 && !hr; k++) begin
      @(negedge clk_sys);
      ha = req.arvalid && rsp.arready;
      hr = req.rready && rsp.rvalid;
      v = rsp.rdata[7:0];
      resp = rsp.rresp;
      @(posedge clk_sys);
      if (ha) req.arvalid <= 1'b0;
      if (hr) req.rready <= 1'b0;
    end
    if (!hr) stall("read");
  endtask

  task automatic wait_rise(input int lim, output int cyc);
    logic p;
    logic seen;
    p = event_pulse;
    seen = 1'b0;
    for (cyc = 0; cyc < lim && !seen; cyc++) begin
      @(negedge clk_sys);
      seen = !p && event_pulse;
      p = event_pulse;
    end
    if (!seen) stall("event pulse");
  endtask

  task automatic hold(input string nm);
    logic [7:0] d0, d1;
    logic [1:0] q;
    rd(5'h08, d0, q);
    repeat (40) @(posedge clk_sys);
    rd(5'h08, d1, q);
    chk(nm, d0, d1);
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, r);
      chk("write resp", rows[i].rs, r);
      rd(rows[i].a, d, r);
      chk("read back", rows[i].e, d);
      chk("read resp", rows[i].rs, r);
    end
    // Second reset in mid-run clears what the rows left behind
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(5'(i * 4), d, r);
      chk("reset value", (i == 3) ? 8'hff : 8'h00, d);
    end
    foreach (cs[i]) begin
      wr(5'h04, {cs[i], asy[i], 4'h0}, r);
      wr(5'h08, 8'h00, r);
      wr(5'h00, 8'h80, r);
      run <= 1'b1;
      repeat (160) @(posedge clk_sys);
      run <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rd(5'h08, d, r);
      chk("pin count", ecnt[i], d);
    end
    wr(5'h0c, 8'h03, r);
    wr(5'h04, 8'h41, r);
    wr(5'h08, 8'hfd, r);
    wr(5'h00, 8'h82, r);
    wait_rise(400, n);
    t0 = event_toggle;
    wait_rise(400, n);
    chk("scaled period", 96, n);
    chk("derived toggle", !t0, event_toggle);
    rd(5'h00, d, r);
    chk("output status", 8'ha2, d);
    wr(5'h00, 8'h10, r);
    wr(5'h04, 8'h40, r);
    wr(5'h0c, 8'hff, r);
    wr(5'h08, 8'hfd, r);
    wr(5'h10, 8'h02, r);
    wr(5'h00, 8'h90, r);
    wait_rise(200, n);
    rd(5'h10, d, r);
    chk("event flag", 8'h03, d);
    chk("irq out", 1'b1, event_irq);
    rd(5'h08, d, r);
    rd(5'h0c, d, r);
    chk("latched high", 8'h00, d);
    sleep_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("wake", 1'b1, wake_req);
    hold("sleep hold");
    sleep_active <= 1'b0;
    wr(5'h00, 8'h10, r);
    hold("disabled hold");
    wrap_up();
  end
endmodule

bind tmrz_timer tmrz_timer_properties tmrz_timer_properties_i (.clk_sys(clk_sys),
  .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp), .src_in(src_in),
  .sleep_active(sleep_active), .event_pulse(event_pulse), .event_toggle(event_toggle),
  .event_irq(event_irq), .wake_req(wake_req));
